//--- inc/aeqs_pkg.sv
package aeqs_pkg;
  localparam int unsigned NUM_PORTS = 2;
  localparam int unsigned GAIN_W = 4;
  localparam logic [GAIN_W-1:0] GAIN_MAX = 4'hf;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned ADDR_W = 12;
  localparam logic [7:0] CTL1_IDX = 8'h35;
  localparam logic [7:0] STATUS_IDX = 8'h3b;
  localparam logic [7:0] CTL2_IDX = 8'h45;
  localparam logic [ADDR_W-1:0] CTL1_ADDR = {4'h0, CTL1_IDX} << 2;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = {4'h0, STATUS_IDX} << 2;
  localparam logic [ADDR_W-1:0] CTL2_ADDR = {4'h0, CTL2_IDX} << 2;
  localparam int unsigned CTL1_RESTART_BIT = 0;
  localparam int unsigned CTL1_OVERRIDE_BIT = 1;
  localparam int unsigned CTL1_APPLY_BIT = 2;
  localparam logic [7:0] CTL1_MASK = 8'h06;
  localparam logic [7:0] CTL1_RESET = 8'h00;
  localparam int unsigned CTL2_FLOOR_LSB = 4;
  localparam int unsigned CTL2_DWELL_LSB = 0;
  localparam logic [7:0] CTL2_MASK = 8'hf3;
  localparam logic [1:0] DWELL_SEL_DEFAULT = 2'h2;
  localparam logic [7:0] CTL2_RESET = 8'h02;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned DWELL_DEFAULT_NS = 2620000;
  localparam int unsigned DWELL_DEFAULT_CYC = DWELL_DEFAULT_NS / CLK_PERIOD_NS;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {AEQS_SEARCH, AEQS_HOLD} aeqs_state_e;
endpackage

//--- inc/aeqs_lane_if.sv
`timescale 1ns/1ps
`default_nettype none
interface aeqs_lane_if;
  logic restart;
  logic floor_en;
  logic [aeqs_pkg::GAIN_W-1:0] floor_val;
  logic [aeqs_pkg::CNT_W-1:0] dwell_cyc;
  logic lock;
  logic [aeqs_pkg::GAIN_W-1:0] gain;
  logic holding;
  modport ctrl (
    output restart, floor_en, floor_val, dwell_cyc, lock,
    input gain, holding
  );
  modport lane (
    input restart, floor_en, floor_val, dwell_cyc, lock,
    output gain, holding
  );
endinterface
`default_nettype wire

//--- rtl/aeqs_lane.sv
`timescale 1ns/1ps
`default_nettype none
module aeqs_lane (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control and status
  aeqs_lane_if.lane lif
);
  typedef struct packed {
    aeqs_pkg::aeqs_state_e state;
    logic [aeqs_pkg::GAIN_W-1:0] gain;
    logic [aeqs_pkg::CNT_W-1:0] cnt;
  } aeqs_lane_s;

  aeqs_lane_s s_reg;
  aeqs_lane_s s_next;
  logic [aeqs_pkg::GAIN_W-1:0] start_gain;
  logic [aeqs_pkg::GAIN_W-1:0] adv_gain;
  logic dwell_end;

  assign start_gain = lif.floor_en ? lif.floor_val : '0;
  // Past the top the search wraps instead of climbing further.
  assign adv_gain = (s_reg.gain == aeqs_pkg::GAIN_MAX) ? start_gain
    : s_reg.gain + 4'h1;
  // A compare, not an equality, so that shortening the dwell mid-count
  // cannot strand the counter above its new end.
  assign dwell_end = s_reg.cnt >= lif.dwell_cyc - 20'h1;

  always_comb
  begin
    s_next = s_reg;
    if (lif.restart)
    begin
      s_next.state = aeqs_pkg::AEQS_SEARCH;
      s_next.gain = start_gain;
      s_next.cnt = '0;
    end
    else
    begin
      case (s_reg.state)
        aeqs_pkg::AEQS_SEARCH:
        begin
          s_next.cnt = s_reg.cnt + 20'h1;
          if (dwell_end)
          begin
            s_next.cnt = '0;
            if (lif.lock)
              s_next.state = aeqs_pkg::AEQS_HOLD;
            else
              s_next.gain = adv_gain;
          end
        end
        aeqs_pkg::AEQS_HOLD:
        begin
          if (!lif.lock)
          begin
            s_next.state = aeqs_pkg::AEQS_SEARCH;
            s_next.gain = adv_gain;
          end
        end
        default:
          s_next.state = aeqs_pkg::AEQS_SEARCH;
      endcase
    end
  end

  // Searching starts at reset with no signal present.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= '{aeqs_pkg::AEQS_SEARCH, '0, '0};
    else
      s_reg <= s_next;
  end

  assign lif.gain = s_reg.gain;
  assign lif.holding = s_reg.state == aeqs_pkg::AEQS_HOLD;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_hold_gain: assert property (
    lif.holding && lif.lock && !lif.restart |=> $stable(s_reg.gain)
  ) else $error("gain moved while locked");
  a_dwell_stable: assert property (
    !lif.holding && !dwell_end && !lif.restart |=> $stable(s_reg.gain)
  ) else $error("gain moved inside dwell");
  a_step_up: assert property (
    !lif.holding && dwell_end && !lif.lock && !lif.restart
    && s_reg.gain != aeqs_pkg::GAIN_MAX
    |=> s_reg.gain == $past(s_reg.gain) + 4'h1
  ) else $error("gain did not step by one");
  a_wrap_start: assert property (
    !lif.holding && dwell_end && !lif.lock && !lif.restart
    && s_reg.gain == aeqs_pkg::GAIN_MAX
    |=> s_reg.gain == $past(start_gain)
  ) else $error("gain did not wrap to start");
  a_lock_loss: assert property (
    lif.holding && !lif.lock && !lif.restart
    |=> !lif.holding && s_reg.gain == $past(adv_gain)
  ) else $error("lock loss did not advance gain");
  a_restart_load: assert property (
    lif.restart |=> s_reg.gain == $past(start_gain) && s_reg.cnt == '0
  ) else $error("restart did not load start gain");
endmodule
`default_nettype wire

//--- rtl/aeqs_top.sv
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module aeqs_top #(
  parameter int unsigned DWELL_CYC = aeqs_pkg::DWELL_DEFAULT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // AXI4-Lite write address
  input wire logic [aeqs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [aeqs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive ports
  input wire logic [aeqs_pkg::NUM_PORTS-1:0] cdr_lock_i,
  output logic [aeqs_pkg::NUM_PORTS*aeqs_pkg::GAIN_W-1:0] eq_gain_o,
  output logic [aeqs_pkg::NUM_PORTS-1:0] eq_holding_o
);

  ////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic aw_got;
    logic [aeqs_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [7:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic restart;
    logic [aeqs_pkg::NUM_PORTS-1:0] lock_meta;
    logic [aeqs_pkg::NUM_PORTS-1:0] lock_sync;
  } aeqs_top_s;

  localparam aeqs_top_s RESET_STATE = '{
    aw_got: 1'b0,
    aw_addr: '0,
    w_got: 1'b0,
    w_data: 8'h00,
    w_strb0: 1'b0,
    bvalid: 1'b0,
    bresp: aeqs_pkg::RESP_OKAY,
    rvalid: 1'b0,
    rdata: 32'h0000_0000,
    rresp: aeqs_pkg::RESP_OKAY,
    ctl1: aeqs_pkg::CTL1_RESET,
    ctl2: aeqs_pkg::CTL2_RESET,
    restart: 1'b0,
    lock_meta: '0,
    lock_sync: '0
  };

  // Only the counter's width is kept, so DWELL_CYC must fit in it.
  localparam logic [aeqs_pkg::CNT_W-1:0] DWELL_BASE =
    DWELL_CYC[aeqs_pkg::CNT_W-1:0];

  aeqs_top_s s_reg;
  aeqs_top_s s_next;

  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic wr_ctl1;
  logic wr_ctl2;
  logic wr_status;
  logic rd_ctl1;
  logic rd_ctl2;
  logic rd_status;
  logic floor_en;
  logic [aeqs_pkg::GAIN_W-1:0] floor_val;
  logic [1:0] dwell_sel;
  logic [aeqs_pkg::CNT_W-1:0] dwell_cyc;
  logic [7:0] status_val;
  logic [aeqs_pkg::GAIN_W-1:0] lane_gain [aeqs_pkg::NUM_PORTS];
  logic [aeqs_pkg::NUM_PORTS-1:0] lane_hold;

  ////////////////////////////////////////////////////////////////////////////

  // One write and one read at most are in flight; address and data
  // are each parked until the other arrives.
  assign s_axi_awready = !s_reg.aw_got && !s_reg.bvalid;
  assign s_axi_wready = !s_reg.w_got && !s_reg.bvalid;
  assign s_axi_arready = !s_reg.rvalid;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_fire = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;

  assign wr_ctl1 =
    s_reg.aw_addr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::CTL1_ADDR[11:2];
  assign wr_ctl2 =
    s_reg.aw_addr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::CTL2_ADDR[11:2];
  assign wr_status =
    s_reg.aw_addr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::STATUS_ADDR[11:2];
  assign rd_ctl1 =
    s_axi_araddr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::CTL1_ADDR[11:2];
  assign rd_ctl2 =
    s_axi_araddr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::CTL2_ADDR[11:2];
  assign rd_status =
    s_axi_araddr[aeqs_pkg::ADDR_W-1:2] == aeqs_pkg::STATUS_ADDR[11:2];

  ////////////////////////////////////////////////////////////////////////////

  // The floor counts only when both enabling bits are set.
  assign floor_en = s_reg.ctl1[aeqs_pkg::CTL1_OVERRIDE_BIT]
    && s_reg.ctl1[aeqs_pkg::CTL1_APPLY_BIT];
  assign floor_val = s_reg.ctl2[aeqs_pkg::CTL2_FLOOR_LSB +:
    aeqs_pkg::GAIN_W];
  assign dwell_sel = s_reg.ctl2[aeqs_pkg::CTL2_DWELL_LSB +: 2];

  // Quarter, half, one and two times the base dwell; the base must be
  // at least four cycles so that the shortest choice is not zero.
  always_comb
  begin
    case (dwell_sel)
      2'h0: dwell_cyc = DWELL_BASE >> 2;
      2'h1: dwell_cyc = DWELL_BASE >> 1;
      2'h2: dwell_cyc = DWELL_BASE;
      2'h3: dwell_cyc = DWELL_BASE << 1;
      default: dwell_cyc = DWELL_BASE;
    endcase
  end

  assign status_val = {lane_gain[1], lane_gain[0]};

  ////////////////////////////////////////////////////////////////////////////

  always_comb
  begin
    s_next = s_reg;
    s_next.lock_meta = cdr_lock_i;
    s_next.lock_sync = s_reg.lock_meta;
    s_next.restart = 1'b0;
    if (aw_hs)
    begin
      s_next.aw_got = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (w_hs)
    begin
      s_next.w_got = 1'b1;
      s_next.w_data = s_axi_wdata[7:0];
      s_next.w_strb0 = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      s_next.aw_got = 1'b0;
      s_next.w_got = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = aeqs_pkg::RESP_OKAY;
      if (wr_ctl1)
      begin
        if (s_reg.w_strb0)
        begin
          s_next.ctl1 = s_reg.w_data & aeqs_pkg::CTL1_MASK;
          // Self-clearing: the restart bit is a one-cycle strobe.
          s_next.restart =
            s_reg.w_data[aeqs_pkg::CTL1_RESTART_BIT];
        end
      end
      else if (wr_ctl2)
      begin
        if (s_reg.w_strb0)
          s_next.ctl2 = s_reg.w_data & aeqs_pkg::CTL2_MASK;
      end
      else if (!wr_status)
        s_next.bresp = aeqs_pkg::RESP_SLVERR;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (ar_hs)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = aeqs_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (rd_ctl1)
        s_next.rdata[7:0] = s_reg.ctl1;
      else if (rd_ctl2)
        s_next.rdata[7:0] = s_reg.ctl2;
      else if (rd_status)
        s_next.rdata[7:0] = status_val;
      else
        s_next.rresp = aeqs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      s_reg <= RESET_STATE;
    else
      s_reg <= s_next;
  end

  assign s_axi_bvalid = s_reg.bvalid;
  assign s_axi_bresp = s_reg.bresp;
  assign s_axi_rvalid = s_reg.rvalid;
  assign s_axi_rdata = s_reg.rdata;
  assign s_axi_rresp = s_reg.rresp;

  ////////////////////////////////////////////////////////////////////////////

  // Each receive port owns its own search engine.
  for (genvar p = 0; p < aeqs_pkg::NUM_PORTS; p++)
  begin : g_lane
    aeqs_lane_if lif ();
    assign lif.restart = s_reg.restart;
    assign lif.floor_en = floor_en;
    assign lif.floor_val = floor_val;
    assign lif.dwell_cyc = dwell_cyc;
    assign lif.lock = s_reg.lock_sync[p];
    assign lane_gain[p] = lif.gain;
    assign lane_hold[p] = lif.holding;
    assign eq_gain_o[p*aeqs_pkg::GAIN_W +: aeqs_pkg::GAIN_W] = lif.gain;
    aeqs_lane u_lane (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .lif(lif)
    );
  end

  assign eq_holding_o = lane_hold;

  ////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_floor_on: assert property (
    wr_fire && wr_ctl1 && s_reg.w_strb0 && s_reg.w_data[2:1] == 2'h3
    |=> floor_en
  ) else $error("floor not enabled by both bits");
  a_floor_off: assert property (
    wr_fire && wr_ctl1 && s_reg.w_strb0 && s_reg.w_data[2:1] != 2'h3
    |=> !floor_en
  ) else $error("floor enabled without both bits");
  a_restart_pulse: assert property (
    wr_fire && wr_ctl1 && s_reg.w_strb0 && s_reg.w_data[0]
    |=> s_reg.restart ##1 !s_reg.restart
  ) else $error("restart strobe not one cycle");
  a_status_read: assert property (
    ar_hs && rd_status
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(status_val)
  ) else $error("status read lost the gain");
  a_dwell_default: assert property (
    dwell_sel == aeqs_pkg::DWELL_SEL_DEFAULT |-> dwell_cyc == DWELL_BASE
  ) else $error("default dwell mismatch");
  a_lock_sync: assert property (
    ##2 s_reg.lock_sync == $past(cdr_lock_i, 2)
  ) else $error("lock sync not two stages");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read data dropped");
  a_write_answer: assert property (
    wr_fire |=> s_axi_bvalid
  ) else $error("write not answered");

  // Refusals, response codes and register side effects, seen on the bus, in the stored registers and at the receive ports.
  a_aw_refused: assert property (
    s_reg.aw_got || s_axi_bvalid |-> !s_axi_awready
  ) else $error("write address taken while busy");
  a_w_refused: assert property (
    s_reg.w_got || s_axi_bvalid |-> !s_axi_wready
  ) else $error("write data taken while busy");
  a_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready
  ) else $error("read address taken while busy");
  a_read_answer: assert property (
    ar_hs |=> s_axi_rvalid
  ) else $error("read not answered");
  a_wr_okay: assert property (
    wr_fire && (wr_ctl1 || wr_ctl2 || wr_status)
    |=> s_axi_bresp == aeqs_pkg::RESP_OKAY
  ) else $error("mapped write not acknowledged okay");
  a_wr_unmapped: assert property (
    wr_fire && !wr_ctl1 && !wr_ctl2 && !wr_status
    |=> s_axi_bresp == aeqs_pkg::RESP_SLVERR
  ) else $error("unmapped write not refused");
  a_rd_unmapped: assert property (
    ar_hs && !rd_ctl1 && !rd_ctl2 && !rd_status
    |=> s_axi_rresp == aeqs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0
  ) else $error("unmapped read not refused");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
  ) else $error("read data upper bits not zero");
  a_restart_reads0: assert property (
    !s_reg.ctl1[aeqs_pkg::CTL1_RESTART_BIT]
  ) else $error("restart bit was stored");
  a_ctl2_spare: assert property (
    s_reg.ctl2[3:2] == 2'h0
  ) else $error("spare search control bits set");
  a_status_ro: assert property (
    wr_fire && wr_status
    |=> $stable(s_reg.ctl1) && $stable(s_reg.ctl2)
  ) else $error("status write changed a register");
  a_restart_gain: assert property (
    s_reg.restart
    |=> eq_gain_o == ($past(floor_en)
      ? {aeqs_pkg::NUM_PORTS{$past(floor_val)}} : '0)
  ) else $error("restart did not reload every port");
  a_restart_search: assert property (
    s_reg.restart |=> eq_holding_o == '0
  ) else $error("restart left a port holding");
endmodule
`default_nettype wire

//--- verification/aeqs_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module aeqs_link_model (
  // Clock
  input wire logic clk_i,
  // Link set-up from the bench
  input wire logic link_i,
  input wire logic [7:0] settle_i,
  input wire logic [7:0] target_i,
  // Equalizer side
  input wire logic [7:0] gain_i,
  output logic [1:0] lock_o
);
  logic [3:0] cnt [2];
  ////////////////////////////////////////////////////////////////////////////
  // Lock needs the right gain for settle_i cycles, so a slow settle tests
  // that the search waits out the whole dwell before judging a setting.
  // The bench holds the link down from time zero, so the first edge
  // clears the model; one process alone drives each of its signals.
  always @(posedge clk_i)
  begin
    for (int p = 0; p < 2; p++)
    begin
      if (!link_i || gain_i[p*4+:4] != target_i[p*4+:4])
      begin
        cnt[p] <= 4'h0;
        lock_o[p] <= 1'b0;
      end
      else if (cnt[p] < settle_i[p*4+:4])
        cnt[p] <= cnt[p] + 4'h1;
      else
        lock_o[p] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [11:0] A1 = aeqs_pkg::CTL1_ADDR;
  localparam logic [11:0] A2 = aeqs_pkg::CTL2_ADDR;
  localparam logic [11:0] AS = aeqs_pkg::STATUS_ADDR;
  logic clk_i, resetn_i, link;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [1:0] br, rr, lk, hold;
  logic awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre;
  logic [7:0] gain, tgt, settle;
  int errors, checks;
  ////////////////////////////////////////////////////////////////////////////
  aeqs_top #(.DWELL_CYC(16)) aeqs_top_i (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .cdr_lock_i(lk), .eq_gain_o(gain),
    .eq_holding_o(hold)
  );
  aeqs_link_model aeqs_link_model_i (
    .clk_i(clk_i), .link_i(link), .settle_i(settle), .target_i(tgt),
    .gain_i(gain), .lock_o(lk)
  );
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    checks++;
    if (got !== ex)
    begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk_i);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (!(ta && tw))
    begin
      @(posedge clk_i);
      if (awv && awr)
      begin
        ta = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wrd)
      begin
        tw = 1'b1;
        wv <= 1'b0;
      end
    end
    do @(posedge clk_i); while (!bv);
    r = br;
    bre <= 1'b0;
    #1;
  endtask
  task automatic rdr(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk_i);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge clk_i); while (!rv);
    d = rd;
    r = rr;
    rre <= 1'b0;
    #1;
  endtask
  // Waits for the next gain change of one port; n is the cycles taken.
  task automatic nxt(input int p, output logic [3:0] g, output int n);
    logic [3:0] o;
    o = gain[p*4+:4];
    n = 0;
    while (gain[p*4+:4] === o && n < 400)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    g = gain[p*4+:4];
  endtask
  task automatic hwait();
    int t;
    t = 0;
    while (hold !== 2'b11 && t < 2000)
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    chk("holding", 32'h3, {30'h0, hold});
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #400000;
    errors++;
    summarize();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [3:0] g, pg;
    int n;
    {resetn_i, link, awv, wv, bre, arv, rre} = 7'h0;
    {awa, ara, wd} = 56'h0;
    tgt = 8'h95;
    settle = 8'ha1;
    errors = 0;
    checks = 0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    rdr(A1, d, r);
    chk("ctl1 reset", 32'h0, d);
    rdr(A2, d, r);
    chk("ctl2 reset", 32'h2, d);
    // With no link at all the search must keep stepping and wrapping.
    nxt(0, pg, n);
    for (int i = 0; i < 17; i++)
    begin
      nxt(0, g, n);
      chk("free step", {28'h0, pg + 4'h1}, {28'h0, g});
      chk("dwell base", 32'd16, n);
      pg = g;
    end
    wr(A2, 8'hc2, r);
    wr(A1, 8'h03, r);
    chk("no apply", 32'h0, {24'h0, gain});
    wr(A1, 8'h07, r);
    chk("floor", 32'hcc, {24'h0, gain});
    rdr(A1, d, r);
    chk("ctl1 read", 32'h6, d);
    nxt(0, g, n);
    chk("floor step", 32'hd, {28'h0, g});
    nxt(0, g, n);
    chk("floor top", 32'he, {28'h0, g});
    nxt(0, g, n);
    chk("max gain", 32'hf, {28'h0, g});
    nxt(0, g, n);
    chk("floor wrap", 32'hc, {28'h0, g});
    chk("wrap dwell", 32'd16, n);
    for (int s = 0; s < 4; s++)
    begin
      wr(A2, {4'hc, 2'h0, s[1:0]}, r);
      nxt(0, g, n);
      nxt(0, g, n);
      chk("dwell sel", 32'd4 << s, n);
    end
    wr(A2, 8'hff, r);
    rdr(A2, d, r);
    chk("ctl2 mask", 32'hf3, d);
    wr(AS, 8'h00, r);
    chk("status wr", {30'h0, aeqs_pkg::RESP_OKAY}, {30'h0, r});
    wr(12'h000, 8'h00, r);
    chk("bad wr", {30'h0, aeqs_pkg::RESP_SLVERR}, {30'h0, r});
    rdr(12'h000, d, r);
    chk("bad rd", {30'h0, aeqs_pkg::RESP_SLVERR}, {30'h0, r});
    chk("bad data", 32'h0, d);
    // Link comes up; port 1 settles slowly but within one dwell.
    wr(A2, 8'h02, r);
    @(posedge clk_i);
    link <= 1'b1;
    wr(A1, 8'h01, r);
    chk("restart", 32'h0, {24'h0, gain});
    hwait();
    chk("locked", 32'h95, {24'h0, gain});
    rdr(AS, d, r);
    chk("status", 32'h95, d);
    repeat (100) @(posedge clk_i);
    #1;
    chk("held", 32'h95, {24'h0, gain});
    @(posedge clk_i);
    tgt <= 8'h98;
    nxt(0, g, n);
    chk("lost step", 32'h6, {28'h0, g});
    chk("other port", 32'h1, {31'h0, hold[1]});
    hwait();
    chk("relocked", 32'h98, {24'h0, gain});
    wr(A1, 8'h01, r);
    chk("hold restart", 32'h0, {24'h0, gain});
    summarize();
  end
endmodule
`default_nettype wire
